// ---- ocf_pkg.sv ----
// Shared constants and types for the overcurrent fault counter
package ocf_pkg;

  localparam int          clk_rate_hz       = 25000000;
  localparam logic [2:0]  count_reset_value = 3'h0;
  localparam logic [2:0]  count_full        = 3'h7;
  localparam logic [2:0]  count_empty       = 3'h0;

  // Largest duty cycle in percent; switching period counted in sys_clk
  localparam int          max_duty_pct      = 97;
  localparam logic [11:0] period_reset_value = 12'h000;

  // Shortest safe high-side pulse
  localparam int          min_pulse_ns      = 150;
  localparam int          min_pulse_cycles  =
    (min_pulse_ns * (clk_rate_hz / 1000000) + 999) / 1000;

  // Per-cycle indications from the power stage
  typedef struct packed {
    logic pwm_demand;
    logic oc_trip;
  } ocf_stage_type;

  // Soft-start detector indications
  typedef struct packed {
    logic ss_done;
    logic ss_empty;
    logic ss_upper;
  } ocf_ss_type;

endpackage

// ---- ocf_sync.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module ocf_sync
  import ocf_pkg::*;
#(
  parameter int width = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [width-1:0] async_in,
  output logic      [width-1:0] sync_out
);

  logic [width-1:0] stage1;
  logic [width-1:0] stage2;
  logic [width-1:0] stage3;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Change accepted once stages two and three agree
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync_out <= '0;
    end else begin
      for (int i = 0; i < width; i++) begin
        if (stage2[i] == stage3[i]) begin
          sync_out[i] <= stage3[i];
        end
      end
    end
  end

endmodule

// ---- ocf_fault_counter.sv ----
// Overcurrent pulse termination, saturating counter and hiccup control
`timescale 1ns/1ns
// Behaviour
// - Trip during on time ends pulse, counts up
// - No trip in cycle counts down
// - Counter saturates at seven and zero
// - Full count: fault, gates off, discharge
// - Each fault discharge start lowers count
// - Fully discharged cap stops discharging
// - Upper threshold in fault re-discharges, decrements
// - Repeat cycling to zero, gates off
// - Zero count clears fault, soft-start restart
// - Soft-start limits pulses, counts nothing
// - Recovery recharge uses normal source
// - Duty cycle capped at ninety-seven percent
// - Pulses under 150 ns flagged unsafe
module ocf_fault_counter
  import ocf_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        cycle_start,
  input  wire logic [11:0] period_cycles,
  input  ocf_stage_type    stage,
  input  ocf_ss_type       ss_raw,
  input  wire logic        soft_start_shutdown_pin,
  output logic             high_side_gate_drive,
  output logic             low_side_gate_drive,
  output logic             ss_discharge,
  output logic             ss_charge_enable,
  output logic             fault_active,
  output logic             short_pulse_flag,
  output logic [2:0]       oc_count
);

  typedef enum logic [1:0] {
    st_run,
    st_fault_discharge,
    st_fault_charge
  } ocf_state_type;

  ocf_state_type state;
  ocf_state_type next_state;
  ocf_ss_type    ss;
  logic          shutdown_n;
  logic          on_phase;
  logic          on_phase_d;
  logic          trip_latched;
  logic [11:0]   on_count;
  logic [11:0]   on_limit;
  logic          on_end;
  logic          cycle_trip;
  logic          in_fault;
  logic          dec_event;

  function automatic logic [2:0] sat_step(input logic [2:0] value,
                                          input logic       up);
    if (up) begin
      sat_step = (value == count_full) ? count_full : value + 3'h1;
    end else begin
      sat_step = (value == count_empty) ? count_empty : value - 3'h1;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  ocf_sync #(
    .width (4)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({ss_raw, soft_start_shutdown_pin}),
    .sync_out ({ss, shutdown_n})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pulse shaping

  assign on_limit = 12'((32'(period_cycles) * max_duty_pct) / 100);
  assign in_fault = (state != st_run);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      on_phase <= 1'b0;
      on_count <= period_reset_value;
    end else if (cycle_start) begin
      on_phase <= stage.pwm_demand && shutdown_n && !in_fault;
      on_count <= period_reset_value;
    end else if (on_phase) begin
      on_count <= on_count + 12'h001;
      // trip ends the pulse at once
      if (stage.oc_trip || !stage.pwm_demand || !shutdown_n || in_fault ||
          on_count + 12'h001 >= on_limit) begin
        on_phase <= 1'b0;
      end
    end
  end

  // high side off outside the on phase, low side on outside the on phase unless fault or shutdown
  // Fault or shutdown blanks a pulse already in flight
  assign high_side_gate_drive = on_phase && !stage.oc_trip && shutdown_n &&
                                !in_fault;
  assign low_side_gate_drive  = !on_phase && shutdown_n && !in_fault;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      on_phase_d   <= 1'b0;
      trip_latched <= 1'b0;
    end else begin
      on_phase_d <= on_phase;
      // Trip wins over a same-cycle clear
      if (on_phase && stage.oc_trip) begin
        trip_latched <= 1'b1;
      end else if (cycle_start) begin
        trip_latched <= 1'b0;
      end
    end
  end

  assign on_end     = on_phase_d && !on_phase;
  assign cycle_trip = trip_latched || stage.oc_trip;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      short_pulse_flag <= 1'b0;
    end else if (on_end) begin
      short_pulse_flag <= (on_count < 12'(min_pulse_cycles));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hiccup state machine

  always_comb begin
    next_state = state;
    dec_event  = 1'b0;
    unique case (state)
      st_run: begin
        if (oc_count == count_full) begin
          next_state = st_fault_discharge;
          dec_event  = 1'b1;
        end
      end
      st_fault_discharge: begin
        if (ss.ss_empty) begin
          next_state = (oc_count == count_empty) ? st_run : st_fault_charge;
        end
      end
      st_fault_charge: begin
        if (ss.ss_upper) begin
          next_state = st_fault_discharge;
          dec_event  = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= st_run;
    end else if (!shutdown_n) begin
      state <= st_run;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      oc_count <= count_reset_value;
    end else if (!shutdown_n) begin
      oc_count <= count_reset_value;
    end else if (dec_event) begin
      oc_count <= sat_step(oc_count, 1'b0);
    end else if (state == st_run && on_end && ss.ss_done) begin
      oc_count <= sat_step(oc_count, cycle_trip);
    end
  end

  assign ss_discharge     = (state == st_fault_discharge) || !shutdown_n;
  assign ss_charge_enable = !ss_discharge;
  assign fault_active     = in_fault;

endmodule

// ---- ocf_fault_counter_sva.sv ----
// Port assertions for the overcurrent fault counter
`timescale 1ns/1ns
module ocf_fault_sva
  import ocf_pkg::*;
(
  input logic          sys_clk,
  input logic          rst,
  input logic          cycle_start,
  input logic [11:0]   period_cycles,
  input ocf_stage_type stage,
  input ocf_ss_type    ss_raw,
  input logic          soft_start_shutdown_pin,
  input logic          high_side_gate_drive,
  input logic          low_side_gate_drive,
  input logic          ss_discharge,
  input logic          ss_charge_enable,
  input logic          fault_active,
  input logic          short_pulse_flag,
  input logic [2:0]    oc_count
);
  logic [11:0] hi_run;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst) hi_run <= 12'h000;
    else hi_run <= high_side_gate_drive ? hi_run + 12'h001 : 12'h000;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_empty; (fault_active && ss_discharge && ss_raw.ss_empty) [*6];
  endsequence
  sequence s_off; !soft_start_shutdown_pin [*8]; endsequence
  property p_trip; stage.oc_trip |-> !high_side_gate_drive ##1
    (!high_side_gate_drive || $past(cycle_start)); endproperty
  a_trip: assert property (p_trip) else $error("trip");
  property p_full; $rose(fault_active) |-> $past(oc_count) == 3'h7; endproperty
  a_full: assert property (p_full) else $error("full");
  property p_entry; $rose(fault_active) |-> oc_count == 3'h6; endproperty
  a_entry: assert property (p_entry) else $error("entry");
  property p_stop; s_empty |=> !ss_discharge; endproperty
  a_stop: assert property (p_stop) else $error("stop");
  property p_redis; $rose(ss_discharge) && $past(fault_active) |->
    oc_count == $past(oc_count) - 3'h1; endproperty
  a_redis: assert property (p_redis) else $error("redis");
  property p_gates; fault_active |->
    !high_side_gate_drive && !low_side_gate_drive; endproperty
  a_gates: assert property (p_gates) else $error("gates");
  property p_duty;
    int'(hi_run) <= int'(period_cycles) * max_duty_pct / 100; endproperty
  a_duty: assert property (p_duty) else $error("duty");
  property p_off; s_off |-> !high_side_gate_drive &&
    !low_side_gate_drive && oc_count == 3'h0; endproperty
  a_off: assert property (p_off) else $error("off");
endmodule
bind ocf_fault_counter ocf_fault_sva u_sva (.*);

// ---- ocf_cap_model.sv ----
// Soft-start capacitor and its threshold detectors
`timescale 1ns/1ns
module ocf_cap_model
  import ocf_pkg::*;
(
  input  logic       sys_clk,
  input  logic       ss_discharge,
  input  logic       ss_charge_enable,
  output ocf_ss_type ss
);
  localparam int top = 64;
  int level = 0;
  always @(posedge sys_clk)
    if (ss_discharge) level <= 0;
    else if (ss_charge_enable && level < top) level <= level + 1;
  assign ss = {level >= top - 8, level == 0, level >= top};
endmodule

// ---- testbench.sv ----
// Self-checking bench for the overcurrent fault counter
`timescale 1ns/1ns
module testbench;
  import ocf_pkg::*;
  logic          sys_clk = 1'b0;
  logic          rst = 1'b1;
  logic          cycle_start = 1'b0;
  logic [11:0]   period_cycles = 12'h014;
  ocf_stage_type stage = '0;
  ocf_ss_type    ss_raw;
  logic          soft_start_shutdown_pin = 1'b1;
  logic          high_side_gate_drive, low_side_gate_drive, ss_discharge;
  logic          ss_charge_enable, fault_active, short_pulse_flag;
  logic [2:0]    oc_count, exp_cnt;
  logic          t, d0;
  int            err_count = 0;
  int            samples_checked = 0;
  int            w, hc, n;
  always #20 sys_clk = ~sys_clk;
  ocf_fault_counter dut (.*);
  ocf_cap_model cap (.sys_clk, .ss_discharge, .ss_charge_enable, .ss(ss_raw));
  task automatic chk(input logic [2:0] got, input logic [2:0] want);
    samples_checked++;
    if (got !== want) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic final_report;
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic give_up;
    err_count++;
    $display("BAD %0t timeout", $time);
    final_report();
  endtask
  function automatic logic [2:0] step(input logic [2:0] c, input logic tr);
    if (tr) return (c == count_full) ? c : c + 3'h1;
    return (c == count_empty) ? c : c - 3'h1;
  endfunction
  task automatic cyc(input int pw, input logic tr);
    int lim;
    lim = int'(period_cycles) * max_duty_pct / 100;
    hc = 0;
    @(posedge sys_clk);
    cycle_start <= 1'b1;
    stage.pwm_demand <= 1'b1;
    @(posedge sys_clk);
    cycle_start <= 1'b0;
    for (int i = 0; i < 23; i++) begin
      @(negedge sys_clk);
      hc += int'(high_side_gate_drive);
      @(posedge sys_clk);
      stage.pwm_demand <= i < pw;
      stage.oc_trip <= tr && i == pw - 1;
    end
    if (!tr && pw <= 15) chk(short_pulse_flag, hc < min_pulse_cycles);
    if (!tr && pw >= 17) chk(3'(hc - lim), 3'h0);
  endtask
  task automatic wait_done;
    for (int i = 0; !ss_raw.ss_done; i++) begin
      if (i == 400) give_up();
      @(posedge sys_clk);
    end
    repeat (6) @(posedge sys_clk);
  endtask
  initial begin
    void'($urandom(82));
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    repeat (2) cyc(5, 1'b1);
    chk(oc_count, 3'h0);
    wait_done();
    repeat (3) cyc(1, 1'b0);
    chk(oc_count, 3'h0);
    exp_cnt = 3'h0;
    for (int k = 0; k < 200 && !fault_active; k++) begin
      w = k < 150 ? $urandom_range(21, 1) : 5;
      t = w <= 15 && (k >= 150 || $urandom_range(3, 0) != 0);
      cyc(w, t);
      exp_cnt = step(exp_cnt, t);
      chk(oc_count, exp_cnt == count_full ? 3'h6 : exp_cnt);
      chk(fault_active, exp_cnt == count_full);
    end
    n = 0;
    d0 = 1'b1;
    for (int i = 0; i < 3000 && fault_active; i++) begin
      @(negedge sys_clk);
      if (ss_discharge && !d0) n++;
      d0 = ss_discharge;
    end
    if (fault_active) give_up();
    chk(3'(n), 3'h6);
    chk({low_side_gate_drive, oc_count[1:0]}, 3'h4);
    chk({ss_discharge, ss_charge_enable, fault_active}, 3'h2);
    wait_done();
    repeat (2) cyc(5, 1'b1);
    chk(oc_count, 3'h2);
    soft_start_shutdown_pin <= 1'b0;
    repeat (10) @(negedge sys_clk);
    chk({high_side_gate_drive, low_side_gate_drive, oc_count[0]}, 3'h0);
    chk(oc_count, 3'h0);
    final_report();
  end
endmodule
